// ==== rtl/ffm_pkg.sv ====
// Constants and types shared by the flyback fault manager.
// Contract
// - Stop PWM after fault persists its delay
// - Filter is longer of 125us, two periods
// - Brownout filtered 40 ms, always auto-restart
// - Unfiltered start-up pin checks block PWM
// - Auto-restart: wait, discharge, retry, repeat
// - Latched: block restarts, regulate supply band
// - AC loss clears latch, fresh start-up
// - Supply over-voltage stops PWM; variant threshold
// - Basic variant latches OV, temp, shutdown faults
// - Supply under-voltage always auto-restarts
// - Overload timer basic only, auto-restart
// - Pin/diag faults latch except low-threshold
// - Over-temp restart waits for 10C cooling
// - Open shutdown pin normal, open drive hiccups
// - Shutdown input low filtered as fault
package ffm_pkg;

    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned FILT_US = 125;
    localparam int unsigned FILT_CYC = (FILT_US * (CLK_HZ / 1_000_000));
    localparam int unsigned FILT_PERIODS = 2;
    localparam int unsigned BROWNOUT_MS = 40;
    localparam int unsigned BROWNOUT_CYC = BROWNOUT_MS * (CLK_HZ / 1000);
    // Restart delays are plain defaults; set per product
    localparam int unsigned LONG_RESTART_MS = 1000;
    localparam int unsigned SHORT_RESTART_MS = 100;
    localparam int unsigned LONG_RESTART_CYC = LONG_RESTART_MS * (CLK_HZ / 1000);
    localparam int unsigned SHORT_RESTART_CYC = SHORT_RESTART_MS * (CLK_HZ / 1000);
    localparam logic [31:0] PIN_CHECK_CYC = 32'h0000_0004;
    localparam int unsigned FCW = 21;
    localparam int unsigned NUM_FILT = 5;
    localparam logic [15:0] OVP_MV_NOM = 16'h445c;
    localparam logic [15:0] OVP_MV_LOW = 16'h3a02;
    localparam logic [FCW-1:0] FILT_RST = {FCW{1'b0}};

    typedef enum logic [1:0] {
        VAR_BASIC,
        VAR_STANDARD,
        VAR_LOW_THRESH,
        VAR_SPARE
    } ffm_variant_e;

    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_PIN_CHECK,
        ST_RUNNING,
        ST_RESTART_WAIT,
        ST_DISCHARGE,
        ST_RESTART,
        ST_LATCHED
    } ffm_state_e;

    // Comparator and analog status levels, asynchronous to core_clk
    typedef struct packed {
        logic supply_ov;
        logic supply_uv;
        logic over_temp;
        logic temp_cooled;
        logic shutdown_input_n;
        logic output_ov;
        logic ac_brownout;
        logic ac_present;
        logic xcap_discharge;
        logic feedback_sense_pin_fault;
        logic gate_drive_pin_short;
        logic gate_drive_pin_open;
        logic current_sense_pin_fault;
        logic vdd_at_reset_level;
        logic vdd_below_band;
        logic vdd_above_band;
    } ffm_sense_s;

    localparam ffm_sense_s SENSE_RST = '0;

endpackage

// ==== rtl/ffm_persist.sv ====
// Persistence filter: time and switching-period qualification.
`timescale 1ns/1ps
`default_nettype none
module ffm_persist
    import ffm_pkg::*;
#(
    parameter int unsigned CYCLES = FILT_CYC,
    parameter int unsigned PERIODS = FILT_PERIODS
) (
    input wire logic core_clk, // Core clock
    input wire logic reset_n, // Async reset, low
    input wire logic fault_in, // Raw fault level
    input wire logic period_tick, // One pulse per PWM period
    input wire logic clear, // Hold filter empty
    output logic qualified // Fault persisted long enough
);

    localparam logic [FCW-1:0] LIM = FCW'(CYCLES);
    localparam logic [1:0] PLIM = 2'(PERIODS);

    typedef struct packed {
        logic [FCW-1:0] cnt;
        logic [1:0] per;
        logic q;
    } ffm_filt_s;

    ffm_filt_s s_r;
    ffm_filt_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (clear || !fault_in) begin
            s_nxt.cnt = FILT_RST;
            s_nxt.per = 2'h0;
            s_nxt.q = 1'b0;
        end else begin
            if (s_r.cnt != LIM) begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
            if (period_tick && s_r.per != PLIM) begin
                s_nxt.per = s_r.per + 2'h1;
            end
            s_nxt.q = (s_r.cnt == LIM) && (s_r.per == PLIM);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign qualified = s_r.q;

endmodule
`default_nettype wire

// ==== rtl/ffm_fault_manager.sv ====
// Fault supervision state machine of the flyback controller.
`timescale 1ns/1ps
`default_nettype none
module ffm_fault_manager
    import ffm_pkg::*;
#(
    parameter int unsigned BROWNOUT_CYCLES = BROWNOUT_CYC,
    parameter int unsigned LONG_RESTART_CYCLES = LONG_RESTART_CYC,
    parameter int unsigned SHORT_RESTART_CYCLES = SHORT_RESTART_CYC
) (
    input wire logic core_clk, // Core clock, 25 MHz
    input wire logic reset_n, // Async reset, low
    input wire ffm_variant_e variant_sel, // Fixed variant strap
    input wire ffm_sense_s sense_in, // Async analog status
    input wire logic internal_diag_fault, // Diagnostics, same clock
    input wire logic overload_trip, // Overload timer expired
    input wire logic pwm_period_tick, // One pulse per PWM period
    output logic pwm_enable, // Modulator may switch
    output logic low_power_mode, // Controller in low power
    output logic high_voltage_start_pin_on, // Start-up source on
    output logic supply_discharge, // Drain supply to reset
    output logic pin_check_active, // Start-up pin tests run
    output logic latched_fault, // Latched hold active
    output logic restart_attempt, // Pulse at each retry
    output logic [15:0] ovp_threshold_mv // Supply OVP trip level
);

    typedef struct packed {
        ffm_sense_s sync1;
        ffm_sense_s sync2;
        ffm_state_e st;
        logic [31:0] cnt;
        logic use_short;
        logic wait_temp;
        logic pwm;
        logic lpm;
        logic hv;
        logic dis;
        logic chk;
        logic latched;
        logic restart;
        logic [15:0] ovp_mv;
    } ffm_core_s;

    localparam logic [31:0] LONG_LIM = 32'(LONG_RESTART_CYCLES);
    localparam logic [31:0] SHORT_LIM = 32'(SHORT_RESTART_CYCLES);

    ffm_core_s s_r;
    ffm_core_s s_nxt;
    ffm_sense_s f;
    logic [NUM_FILT-1:0] raw_flt;
    logic [NUM_FILT-1:0] q_flt;
    logic q_brownout;
    logic filt_clear;

    ////////////////////////////////////////////////////////////////////
    // Persistence filters

    assign f = s_r.sync2;
    // Filters only arm while switching; stale counts never carry over
    assign filt_clear = (s_r.st != ST_RUNNING);
    assign raw_flt[0] = f.supply_ov;
    assign raw_flt[1] = f.supply_uv;
    assign raw_flt[2] = f.over_temp;
    assign raw_flt[3] = !f.shutdown_input_n;
    assign raw_flt[4] = f.output_ov;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FILT; gi++) begin : g_filt
            ffm_persist #(
                .CYCLES(FILT_CYC),
                .PERIODS(FILT_PERIODS)
            ) u_filt (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .fault_in(raw_flt[gi]),
                .period_tick(pwm_period_tick),
                .clear(filt_clear),
                .qualified(q_flt[gi])
            );
        end
    endgenerate

    ffm_persist #(
        .CYCLES(BROWNOUT_CYCLES),
        .PERIODS(0)
    ) u_brownout (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .fault_in(f.ac_brownout),
        .period_tick(pwm_period_tick),
        .clear(filt_clear),
        .qualified(q_brownout)
    );

    ////////////////////////////////////////////////////////////////////
    // Fault state machine

    function automatic ffm_core_s enter_fault(ffm_core_s c, logic latch, logic short_d, logic temp);
        ffm_core_s r;
        r = c;
        r.pwm = 1'b0;
        r.chk = 1'b0;
        r.dis = 1'b0;
        r.hv = 1'b0;
        r.lpm = 1'b1;
        r.cnt = 32'h0000_0000;
        r.use_short = short_d;
        r.wait_temp = temp;
        r.latched = latch;
        r.st = latch ? ST_LATCHED : ST_RESTART_WAIT;
        return r;
    endfunction

    logic pin_fault;
    logic run_latch;
    logic run_auto;
    logic [31:0] wait_lim;

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = sense_in;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.restart = 1'b0;
        s_nxt.ovp_mv = (variant_sel == VAR_LOW_THRESH) ? OVP_MV_LOW : OVP_MV_NOM;
        pin_fault = f.feedback_sense_pin_fault | f.gate_drive_pin_short | f.current_sense_pin_fault
                    | internal_diag_fault;
        run_latch = (variant_sel == VAR_BASIC) && (q_flt[0] | q_flt[2] | q_flt[3] | q_flt[4]);
        run_auto = (|q_flt) | q_brownout | (overload_trip && variant_sel == VAR_BASIC);
        wait_lim = s_r.use_short ? SHORT_LIM : LONG_LIM;
        case (s_r.st)
            ST_POWER_UP: begin
                s_nxt.pwm = 1'b0;
                s_nxt.lpm = 1'b0;
                s_nxt.hv = 1'b1;
                s_nxt.latched = 1'b0;
                if (f.ac_present && !f.supply_uv) begin
                    s_nxt.st = ST_PIN_CHECK;
                    s_nxt.cnt = 32'h0000_0000;
                    s_nxt.chk = 1'b1;
                end
            end
            ST_PIN_CHECK: begin
                s_nxt.hv = 1'b0;
                s_nxt.cnt = s_r.cnt + 32'h0000_0001;
                if (s_r.cnt == PIN_CHECK_CYC - 32'h0000_0001) begin
                    if (pin_fault) begin
                        s_nxt = enter_fault(s_nxt, variant_sel != VAR_LOW_THRESH, 1'b0, 1'b0);
                    end else if (f.gate_drive_pin_open) begin
                        s_nxt = enter_fault(s_nxt, 1'b0, 1'b0, 1'b0);
                    end else begin
                        s_nxt.chk = 1'b0;
                        s_nxt.st = ST_RUNNING;
                        s_nxt.pwm = 1'b1;
                    end
                end
            end
            ST_RUNNING: begin
                if (run_latch || run_auto) begin
                    s_nxt = enter_fault(s_nxt, run_latch, q_brownout | f.xcap_discharge, q_flt[2]);
                end
            end
            ST_RESTART_WAIT: begin
                if (s_r.cnt != wait_lim) begin
                    s_nxt.cnt = s_r.cnt + 32'h0000_0001;
                end else if (!s_r.wait_temp || f.temp_cooled) begin
                    s_nxt.st = ST_DISCHARGE;
                    s_nxt.dis = 1'b1;
                end
            end
            ST_DISCHARGE: begin
                if (f.vdd_at_reset_level) begin
                    s_nxt.dis = 1'b0;
                    s_nxt.lpm = 1'b0;
                    s_nxt.hv = 1'b1;
                    s_nxt.st = ST_RESTART;
                    s_nxt.restart = 1'b1;
                end
            end
            ST_RESTART: begin
                if (f.ac_present && !f.supply_uv) begin
                    s_nxt.st = ST_PIN_CHECK;
                    s_nxt.cnt = 32'h0000_0000;
                    s_nxt.chk = 1'b1;
                end
            end
            ST_LATCHED: begin
                if (f.vdd_below_band) begin
                    s_nxt.hv = 1'b1;
                end else if (f.vdd_above_band) begin
                    s_nxt.hv = 1'b0;
                end
                if (!f.ac_present) begin
                    s_nxt.st = ST_POWER_UP;
                    s_nxt.latched = 1'b0;
                    s_nxt.lpm = 1'b0;
                    s_nxt.hv = 1'b1;
                end
            end
            default: begin
                s_nxt.st = ST_POWER_UP;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '{sync1: SENSE_RST, sync2: SENSE_RST, st: ST_POWER_UP, cnt: 32'h0000_0000,
                     use_short: 1'b0, wait_temp: 1'b0, pwm: 1'b0, lpm: 1'b0, hv: 1'b0,
                     dis: 1'b0, chk: 1'b0, latched: 1'b0, restart: 1'b0, ovp_mv: OVP_MV_NOM};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pwm_enable = s_r.pwm;
    assign low_power_mode = s_r.lpm;
    assign high_voltage_start_pin_on = s_r.hv;
    assign supply_discharge = s_r.dis;
    assign pin_check_active = s_r.chk;
    assign latched_fault = s_r.latched;
    assign restart_attempt = s_r.restart;
    assign ovp_threshold_mv = s_r.ovp_mv;

endmodule
`default_nettype wire

// ==== bench/ffm_fault_manager_sva.sv ====
// Port checker of the flyback fault manager.
`timescale 1ns/1ps
`default_nettype none
module ffm_fault_manager_sva
    import ffm_pkg::*;
#(
    parameter int unsigned BROWNOUT_CYCLES = BROWNOUT_CYC,
    parameter int unsigned LONG_RESTART_CYCLES = LONG_RESTART_CYC,
    parameter int unsigned SHORT_RESTART_CYCLES = SHORT_RESTART_CYC
) (
    input wire logic core_clk, // Core clock
    input wire logic reset_n, // Async reset, low
    input wire ffm_variant_e variant_sel, // Variant strap
    input wire ffm_sense_s sense_in, // Analog status
    input wire logic internal_diag_fault, // Diagnostics
    input wire logic overload_trip, // Overload expired
    input wire logic pwm_period_tick, // PWM period pulse
    input wire logic pwm_enable, // Modulator on
    input wire logic low_power_mode, // Low power
    input wire logic high_voltage_start_pin_on, // Start-up source
    input wire logic supply_discharge, // Supply drain
    input wire logic pin_check_active, // Pin tests
    input wire logic latched_fault, // Latched hold
    input wire logic restart_attempt, // Retry pulse
    input wire logic [15:0] ovp_threshold_mv // OVP level
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    a_latch_blocks_pwm: assert property (latched_fault |-> !pwm_enable && low_power_mode)
        else $error("pwm on while latched");
    a_pwm_state_quiet: assert property (pwm_enable |-> !low_power_mode && !pin_check_active)
        else $error("pwm on outside running");
    a_pin_check_len: assert property ($rose(pin_check_active) |-> pin_check_active[*4] ##1 !pin_check_active)
        else $error("pin check length wrong");
    a_pwm_after_check: assert property ($rose(pwm_enable) |-> $past(pin_check_active))
        else $error("pwm without pin check");
    a_restart_single: assert property (restart_attempt |=> !restart_attempt)
        else $error("restart pulse too long");
    a_restart_cause: assert property (restart_attempt |-> $past(supply_discharge) && !low_power_mode)
        else $error("restart without discharge");
    a_discharge_delay: assert property ($rose(supply_discharge) |-> $past(low_power_mode, 9))
        else $error("discharge before restart delay");
    a_discharge_auto: assert property (supply_discharge |-> !latched_fault && !pwm_enable)
        else $error("discharge in wrong state");
    a_ovp_low_level: assert property (variant_sel == VAR_LOW_THRESH |=> ovp_threshold_mv == OVP_MV_LOW)
        else $error("low ovp level wrong");
    a_ovp_nom_level: assert property (variant_sel != VAR_LOW_THRESH |=> ovp_threshold_mv == OVP_MV_NOM)
        else $error("nominal ovp level wrong");
    c_restart: cover property (restart_attempt);
    c_latch: cover property ($rose(latched_fault));
    c_run: cover property ($rose(pwm_enable));
endmodule
bind ffm_fault_manager ffm_fault_manager_sva #(.BROWNOUT_CYCLES(BROWNOUT_CYCLES),
    .LONG_RESTART_CYCLES(LONG_RESTART_CYCLES), .SHORT_RESTART_CYCLES(SHORT_RESTART_CYCLES)) u_sva (
    .core_clk(core_clk), .reset_n(reset_n), .variant_sel(variant_sel), .sense_in(sense_in),
    .internal_diag_fault(internal_diag_fault), .overload_trip(overload_trip), .pwm_period_tick(pwm_period_tick),
    .pwm_enable(pwm_enable), .low_power_mode(low_power_mode), .high_voltage_start_pin_on(high_voltage_start_pin_on),
    .supply_discharge(supply_discharge), .pin_check_active(pin_check_active), .latched_fault(latched_fault),
    .restart_attempt(restart_attempt), .ovp_threshold_mv(ovp_threshold_mv));
`default_nettype wire

// ==== bench/ffm_plant.sv ====
// Power stage model: PWM period ticks and supply rail level.
`timescale 1ns/1ps
`default_nettype none
module ffm_plant (
    input wire logic core_clk, // Core clock
    input wire logic reset_n, // Async reset, low
    input wire logic pwm_enable, // Modulator on
    input wire logic supply_discharge, // Drain request
    input wire logic hv_on, // Start-up source on
    output logic period_tick, // One pulse per period
    output logic vdd_at_reset, // Rail at reset level
    output logic vdd_low, // Below hold band
    output logic vdd_high // Above hold band
);
    logic [2:0] ph;
    logic [4:0] lvl;
    always @(negedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph <= 3'h0;
            lvl <= 5'h0a;
        end else begin
            ph <= ph + 3'h1;
            if (supply_discharge) begin
                lvl <= (lvl > 5'h01) ? lvl - 5'h02 : 5'h00;
            end else if (hv_on && lvl < 5'h14) begin
                lvl <= lvl + 5'h01;
            end else if (!hv_on && !pwm_enable && lvl != 5'h00) begin
                lvl <= lvl - 5'h01;
            end
        end
    end
    assign period_tick = pwm_enable && ph == 3'h0;
    assign vdd_at_reset = lvl == 5'h00;
    assign vdd_low = lvl < 5'h08;
    assign vdd_high = lvl > 5'h0c;
endmodule
`default_nettype wire

// ==== bench/tb_flyback_fault_manager.sv ====
// Self-checking bench of the flyback fault manager.
`timescale 1ns/1ps
`default_nettype none
module tb_flyback_fault_manager
    import ffm_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    ffm_variant_e variant_sel = VAR_STANDARD;
    ffm_sense_s tb_s = '{ac_present: 1'b1, shutdown_input_n: 1'b1, default: 1'b0};
    ffm_sense_s sense;
    logic diag = 1'b0;
    logic ovl = 1'b0;
    logic tick, p_rst, p_lo, p_hi, pwm, lpm, hv, dis, pchk, lat, rsa;
    logic [15:0] ovp;
    int n_mismatch = 0;
    int tests_run = 0;
    int n;
    always #20 core_clk = ~core_clk;
    always_comb begin
        sense = tb_s;
        sense.vdd_at_reset_level = p_rst;
        sense.vdd_below_band = p_lo;
        sense.vdd_above_band = p_hi;
    end
    ffm_fault_manager #(.BROWNOUT_CYCLES(50), .LONG_RESTART_CYCLES(40), .SHORT_RESTART_CYCLES(10)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .variant_sel(variant_sel), .sense_in(sense),
        .internal_diag_fault(diag), .overload_trip(ovl), .pwm_period_tick(tick), .pwm_enable(pwm),
        .low_power_mode(lpm), .high_voltage_start_pin_on(hv), .supply_discharge(dis), .pin_check_active(pchk),
        .latched_fault(lat), .restart_attempt(rsa), .ovp_threshold_mv(ovp));
    ffm_plant plant (.core_clk(core_clk), .reset_n(reset_n), .pwm_enable(pwm), .supply_discharge(dis),
        .hv_on(hv), .period_tick(tick), .vdd_at_reset(p_rst), .vdd_low(p_lo), .vdd_high(p_hi));
    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return pwm;
            1: return lat;
            2: return pchk;
            3: return dis;
            4: return rsa;
            default: return hv;
        endcase
    endfunction
    // Bounded wait; n returns the cycles spent
    task automatic waitv(input int k, input logic v, input int lim, output int c);
        c = 0;
        while (pick(k) !== v && c < lim) begin
            @(negedge core_clk);
            c++;
        end
        chk($sformatf("wait%0d", k), pick(k), v);
    endtask
    task automatic rst(input ffm_variant_e v);
        reset_n = 1'b0;
        variant_sel = v;
        repeat (8) @(negedge core_clk);
        chk("pwm_in_reset", {pwm, lpm, lat, dis}, 0);
        chk("ovp_in_reset", ovp, OVP_MV_NOM);
        reset_n = 1'b1;
        @(negedge core_clk);
        chk("ovp", ovp, (v == VAR_LOW_THRESH) ? OVP_MV_LOW : OVP_MV_NOM);
    endtask
    task automatic start();
        waitv(2, 1'b1, 20, n);
        n = 0;
        while (pchk === 1'b1 && n < 10) begin
            n++;
            @(negedge core_clk);
        end
        chk("check_len", n, 4);
        chk("pwm_on", pwm, 1);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_pin();
        for (int i = 0; i < 4; i++) begin
            tb_s.feedback_sense_pin_fault = (i == 1);
            tb_s.current_sense_pin_fault = (i == 0);
            tb_s.gate_drive_pin_open = (i == 2);
            diag = (i == 3);
            rst((i == 1) ? VAR_LOW_THRESH : VAR_STANDARD);
            waitv(2, 1'b1, 20, n);
            waitv(2, 1'b0, 10, n);
            chk("pin_pwm", {pwm, lpm}, 2'b01);
            chk("pin_latch", lat, (i == 0 || i == 3));
        end
        tb_s.feedback_sense_pin_fault = 1'b0;
        tb_s.current_sense_pin_fault = 1'b0;
        tb_s.gate_drive_pin_open = 1'b0;
        diag = 1'b0;
    endtask
    task automatic t_uv();
        tb_s.supply_uv = 1'b1;
        repeat (1000) @(negedge core_clk);
        chk("uv_glitch", pwm, 1);
        tb_s.supply_uv = 1'b0;
        repeat (4) @(negedge core_clk);
        tb_s.supply_uv = 1'b1;
        waitv(0, 1'b0, 5000, n);
        chk("uv_delay", n >= 3125, 1);
        chk("uv_auto", {lpm, lat}, 2'b10);
        waitv(4, 1'b1, 500, n);
        tb_s.supply_uv = 1'b0;
        waitv(0, 1'b1, 100, n);
    endtask
    task automatic t_brown();
        tb_s.ac_brownout = 1'b1;
        waitv(0, 1'b0, 200, n);
        chk("brown_delay", n >= 50, 1);
        waitv(3, 1'b1, 100, n);
        chk("short_wait", n > 8 && n < 13, 1);
        tb_s.ac_brownout = 1'b0;
        waitv(0, 1'b1, 300, n);
    endtask
    task automatic t_temp();
        tb_s.over_temp = 1'b1;
        waitv(0, 1'b0, 5000, n);
        tb_s.over_temp = 1'b0;
        repeat (300) @(negedge core_clk);
        chk("hot_hold", dis, 0);
        tb_s.temp_cooled = 1'b1;
        waitv(0, 1'b1, 300, n);
        tb_s.temp_cooled = 1'b0;
    endtask
    task automatic t_latch();
        tb_s.shutdown_input_n = 1'b0;
        waitv(1, 1'b1, 5000, n);
        tb_s.shutdown_input_n = 1'b1;
        waitv(5, 1'b1, 100, n);
        waitv(5, 1'b0, 100, n);
        repeat (200) @(negedge core_clk);
        chk("latch_hold", {lat, pwm, rsa}, 3'b100);
        tb_s.ac_present = 1'b0;
        waitv(1, 1'b0, 20, n);
        tb_s.ac_present = 1'b1;
        tb_s.xcap_discharge = 1'b1;
        waitv(0, 1'b1, 100, n);
        ovl = 1'b1;
        waitv(0, 1'b0, 20, n);
        chk("ovl_auto", {lat, lpm}, 2'b01);
        waitv(3, 1'b1, 100, n);
        chk("xcap_short", n > 8 && n < 13, 1);
        ovl = 1'b0;
        tb_s.xcap_discharge = 1'b0;
        waitv(0, 1'b1, 300, n);
        tb_s.output_ov = 1'b1;
        waitv(1, 1'b1, 5000, n);
        tb_s.output_ov = 1'b0;
        tb_s.ac_present = 1'b0;
        waitv(1, 1'b0, 20, n);
        tb_s.ac_present = 1'b1;
    endtask
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge core_clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        t_pin();
        rst(VAR_STANDARD);
        start();
        t_uv();
        t_brown();
        t_temp();
        rst(VAR_BASIC);
        start();
        t_latch();
        complete_run();
    end
endmodule
`default_nettype wire
